// [hw/acc_alu_pkg.sv]
// Purpose: shared constants and types for the accumulator add/and slice
// Assumes: 8-bit datapath, one clock domain
// Notes:   operation codes are local to this block
package acc_alu_pkg;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam int unsigned NIBBLE_W = 4;

    typedef enum logic [2:0]
    {
        OP_NONE      = 3'h0,
        OP_SUM_MEM   = 3'h1,
        OP_AND_REG   = 3'h3,
        OP_AND_IMM   = 3'h2,
        OP_AND_MEM   = 3'h6,
        // working register loaded from the immediate by this slice
        OP_LOAD_WORK = 3'h4
    } alu_op_t;

    // flag vector layout
    localparam int unsigned FLAG_C  = 0;
    localparam int unsigned FLAG_AC = 1;
    localparam int unsigned FLAG_Z  = 2;
    localparam int unsigned FLAG_OV = 3;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
endpackage

// [hw/alu_result_if.sv]
// Purpose: carries the combinational result from acc_alu_core to the datapath
// Assumes: one producer, one consumer
// Notes:   flags carry the full new candidate values
interface alu_result_if;
    logic [7:0] result;
    logic       carry;
    logic       half_carry;
    logic       wrap;
    modport producer (output result, output carry, output half_carry, output wrap);
    modport consumer (input result, input carry, input half_carry, input wrap);
endinterface

// [hw/acc_alu_core.sv]
// Purpose: combinational add / and of the working register with an operand
// Assumes: operand already selected by the caller
// Notes:   purely combinational
module acc_alu_core
(
    input  wire logic                  use_sum_i,
    input  wire logic [7:0]            working_i,
    input  wire logic [7:0]            operand_i,
    alu_result_if.producer             res
);
    logic [8:0] full_sum;
    logic [4:0] low_sum;

    always_comb
    begin
        full_sum = {1'b0, working_i} + {1'b0, operand_i};
        low_sum  = {1'b0, working_i[acc_alu_pkg::NIBBLE_W-1:0]} + {1'b0, operand_i[acc_alu_pkg::NIBBLE_W-1:0]};
        if (use_sum_i)
            res.result = full_sum[7:0];
        else
            res.result = working_i & operand_i;
        res.carry      = full_sum[8];
        res.half_carry = low_sum[4];
        // signed wrap: same input signs, different result sign
        res.wrap       = (working_i[7] == operand_i[7]) && (full_sum[7] != working_i[7]);
    end
endmodule // acc_alu_core

// [hw/acc_add_and_datapath.sv]
// Purpose: accumulator add-to-memory and and-family instruction execution
// Assumes: decoder presents one op with its operands for one cycle
// Notes:   memory write-back is a registered strobe with address and data
// Operation
// RULE1: add-to-memory sums working register and memory byte, writes sum to that byte, updates wrap, zero, nibble carry, carry.
// RULE2: and-memory-into-register ands working register with memory byte into working register, zero flag only.
// RULE3: and-immediate ands working register with the immediate into working register, zero flag only.
// RULE4: and-into-memory ands memory byte with working register and writes the result to that byte.
// RULE5: zero flag is set for an all-zero result, cleared otherwise; unlisted flags hold. The code also updates the zero flag for and-into-memory.
module acc_add_and_datapath
#(
    parameter int unsigned ADDR_W = 8
)
(
    input  wire logic                  mclk_i,
    input  wire logic                  rst_b_i,
    input  wire acc_alu_pkg::alu_op_t  op_i,
    input  wire logic [ADDR_W-1:0]     mem_addr_i,
    input  wire logic [7:0]            mem_data_i,
    input  wire logic [7:0]            imm_i,
    output logic [7:0]                 working_register_o,
    output logic                       mem_we_o,
    output logic [ADDR_W-1:0]          mem_waddr_o,
    output logic [7:0]                 mem_wdata_o,
    output logic                       twos_complement_wrap_flag_o,
    output logic                       zero_flag_o,
    output logic                       low_nibble_carry_flag_o,
    output logic                       carry_flag_o
);
    // refuse parameter values the logic cannot serve
    if (ADDR_W < 1 || ADDR_W > 16)
    begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end

    if (acc_alu_pkg::DATA_W != 8)
    begin : g_bad_data_w
        $error("datapath is fixed at one byte");
    end

    if (acc_alu_pkg::NIBBLE_W < 1 || acc_alu_pkg::NIBBLE_W >= acc_alu_pkg::DATA_W)
    begin : g_bad_nibble_w
        $error("nibble carry tap outside the byte");
    end

    if (acc_alu_pkg::FLAG_C > 3 || acc_alu_pkg::FLAG_AC > 3 || acc_alu_pkg::FLAG_Z > 3 || acc_alu_pkg::FLAG_OV > 3)
    begin : g_bad_flag_pos
        $error("flag position outside the flag vector");
    end

    if (acc_alu_pkg::FLAG_C == acc_alu_pkg::FLAG_AC || acc_alu_pkg::FLAG_C == acc_alu_pkg::FLAG_Z
        || acc_alu_pkg::FLAG_C == acc_alu_pkg::FLAG_OV || acc_alu_pkg::FLAG_AC == acc_alu_pkg::FLAG_Z
        || acc_alu_pkg::FLAG_AC == acc_alu_pkg::FLAG_OV || acc_alu_pkg::FLAG_Z == acc_alu_pkg::FLAG_OV)
    begin : g_flag_overlap
        $error("two flags share one position");
    end

    ////////////////////////////////////////////////////////////////////////
    alu_result_if res ();
    logic       fwd_hit;
    logic [7:0] mem_operand;
    logic       use_sum;
    logic [7:0] operand;
    logic       result_zero;

    always_comb
    begin
        // the previous op's write lands only at this edge, so pass its data on
        fwd_hit     = mem_we_o && (mem_waddr_o == mem_addr_i);
        mem_operand = fwd_hit ? mem_wdata_o : mem_data_i;
        use_sum     = (op_i == acc_alu_pkg::OP_SUM_MEM);
        operand     = (op_i == acc_alu_pkg::OP_AND_IMM) ? imm_i : mem_operand;
    end

    acc_alu_core u_core
    (
        .use_sum_i (use_sum),
        .working_i (working_register_o),
        .operand_i (operand),
        .res       (res)
    );

    ////////////////////////////////////////////////////////////////////////
    // zero detect on the shared result
    always_comb
    begin
        result_zero = (res.result == 8'h00); // RULE5
    end

    ////////////////////////////////////////////////////////////////////////
    // working register
    logic [7:0] next_working;

    always_comb
    begin
        next_working = working_register_o;
        case (op_i)
            acc_alu_pkg::OP_AND_REG,
            acc_alu_pkg::OP_AND_IMM:
            begin
                next_working = res.result; // RULE2 RULE3
            end
            acc_alu_pkg::OP_LOAD_WORK:
            begin
                // without this the and ops could never see a set bit
                next_working = imm_i;
            end
            default:
            begin
                next_working = working_register_o;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            working_register_o <= acc_alu_pkg::WORK_RESET;
        end
        else
        begin
            working_register_o <= next_working;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory write port
    logic              next_we;
    logic [ADDR_W-1:0] next_waddr;
    logic [7:0]        next_wdata;

    always_comb
    begin
        next_we    = 1'b0;
        next_waddr = mem_waddr_o;
        next_wdata = mem_wdata_o;
        case (op_i)
            acc_alu_pkg::OP_SUM_MEM,
            acc_alu_pkg::OP_AND_MEM:
            begin
                next_we    = 1'b1; // RULE1 RULE4
                next_waddr = mem_addr_i; // RULE1 RULE4
                next_wdata = res.result; // RULE1 RULE4
            end
            default:
            begin
                next_we = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mem_we_o    <= 1'b0;
            mem_waddr_o <= '0;
            mem_wdata_o <= 8'h00;
        end
        else
        begin
            mem_we_o    <= next_we;
            mem_waddr_o <= next_waddr;
            mem_wdata_o <= next_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags, each output its own flip-flop
    logic [3:0] flags;
    logic [3:0] next_flags;

    always_comb
    begin
        flags                       = '0;
        flags[acc_alu_pkg::FLAG_OV] = twos_complement_wrap_flag_o;
        flags[acc_alu_pkg::FLAG_Z]  = zero_flag_o;
        flags[acc_alu_pkg::FLAG_AC] = low_nibble_carry_flag_o;
        flags[acc_alu_pkg::FLAG_C]  = carry_flag_o;
    end

    always_comb
    begin
        next_flags = flags; // RULE5
        case (op_i)
            acc_alu_pkg::OP_SUM_MEM:
            begin
                next_flags[acc_alu_pkg::FLAG_OV] = res.wrap; // RULE1
                next_flags[acc_alu_pkg::FLAG_AC] = res.half_carry; // RULE1
                next_flags[acc_alu_pkg::FLAG_C]  = res.carry; // RULE1
                next_flags[acc_alu_pkg::FLAG_Z]  = result_zero; // RULE1 RULE5
            end
            acc_alu_pkg::OP_AND_REG,
            acc_alu_pkg::OP_AND_IMM,
            acc_alu_pkg::OP_AND_MEM:
            begin
                // and-into-memory has no flag list of its own; zero follows the and family
                next_flags[acc_alu_pkg::FLAG_Z] = result_zero; // RULE2 RULE3 RULE5
            end
            default:
            begin
                next_flags = flags;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            twos_complement_wrap_flag_o <= acc_alu_pkg::FLAGS_RESET[acc_alu_pkg::FLAG_OV];
            zero_flag_o                 <= acc_alu_pkg::FLAGS_RESET[acc_alu_pkg::FLAG_Z];
            low_nibble_carry_flag_o     <= acc_alu_pkg::FLAGS_RESET[acc_alu_pkg::FLAG_AC];
            carry_flag_o                <= acc_alu_pkg::FLAGS_RESET[acc_alu_pkg::FLAG_C];
        end
        else
        begin
            twos_complement_wrap_flag_o <= next_flags[acc_alu_pkg::FLAG_OV];
            zero_flag_o                 <= next_flags[acc_alu_pkg::FLAG_Z];
            low_nibble_carry_flag_o     <= next_flags[acc_alu_pkg::FLAG_AC];
            carry_flag_o                <= next_flags[acc_alu_pkg::FLAG_C];
        end
    end
endmodule // acc_add_and_datapath

// [tb/mem_model.sv]
// Purpose: data memory on the far side of the slice
// Assumes: write lands at the edge that sees the strobe
// Notes:   read is combinational, so the op sees it at once
module mem_model
(
    input  wire logic       mclk_i,
    input  wire logic       we_i,
    input  wire logic [7:0] waddr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] raddr_i,
    output logic      [7:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'hA5;
    end
    always @(posedge mclk_i)
        if (we_i)
            mem[waddr_i] <= wdata_i;
    assign rdata_o = mem[raddr_i];
endmodule // mem_model

// [tb/acc_alu_sva.sv]
// Purpose: port checks for the add/and slice
// Assumes: one clock, async active-low reset
// Notes:   zero flag of sum and and-into-memory is left to the bench
module acc_alu_sva
#(
    parameter int unsigned ADDR_W = 8
)
(
    input wire logic                 mclk_i,
    input wire logic                 rst_b_i,
    input wire acc_alu_pkg::alu_op_t op_i,
    input wire logic [ADDR_W-1:0]    mem_addr_i,
    input wire logic [7:0]           mem_data_i,
    input wire logic [7:0]           imm_i,
    input wire logic [7:0]           working_register_o,
    input wire logic                 mem_we_o,
    input wire logic [ADDR_W-1:0]    mem_waddr_o,
    input wire logic [7:0]           mem_wdata_o,
    input wire logic                 twos_complement_wrap_flag_o,
    input wire logic                 zero_flag_o,
    input wire logic                 low_nibble_carry_flag_o,
    input wire logic                 carry_flag_o
);
    // the byte an op must see: a write still pending to it wins over memory
    logic [7:0] mem_opnd;
    assign mem_opnd = (mem_we_o && mem_waddr_o == mem_addr_i) ? mem_wdata_o : mem_data_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    property p_sum; op_i == acc_alu_pkg::OP_SUM_MEM |=> mem_we_o
        && {carry_flag_o, mem_wdata_o} == $past(working_register_o) + $past(mem_opnd); endproperty
    a_sum: assert property (p_sum) else $error("sum write wrong");
    property p_andr; op_i == acc_alu_pkg::OP_AND_REG |=> !mem_we_o
        && working_register_o == ($past(working_register_o) & $past(mem_opnd)); endproperty
    a_andr: assert property (p_andr) else $error("and reg wrong");
    property p_andi; op_i == acc_alu_pkg::OP_AND_IMM |=> $stable(carry_flag_o)
        && working_register_o == ($past(working_register_o) & $past(imm_i)); endproperty
    a_andi: assert property (p_andi) else $error("and imm wrong");
    property p_bitwise_product_into_memory_op; op_i == acc_alu_pkg::OP_AND_MEM |=> mem_we_o && $stable(working_register_o)
        && mem_wdata_o == ($past(working_register_o) & $past(mem_opnd)); endproperty
    a_bitwise_product_into_memory_op: assert property (p_bitwise_product_into_memory_op) else $error("and mem wrong");
    property p_zero; op_i inside {acc_alu_pkg::OP_AND_REG, acc_alu_pkg::OP_AND_IMM}
        |=> zero_flag_o == (working_register_o == 8'h00); endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_hold; op_i inside {acc_alu_pkg::OP_AND_REG, acc_alu_pkg::OP_AND_IMM, acc_alu_pkg::OP_AND_MEM}
        |=> $stable(twos_complement_wrap_flag_o) && $stable(low_nibble_carry_flag_o) && $stable(carry_flag_o);
    endproperty
    a_hold: assert property (p_hold) else $error("and op moved an unlisted flag");
    property p_load; op_i == acc_alu_pkg::OP_LOAD_WORK |=> !mem_we_o
        && working_register_o == $past(imm_i) && $stable(zero_flag_o); endproperty
    a_load: assert property (p_load) else $error("working register load wrong");
    cover property (mem_we_o && mem_waddr_o == mem_addr_i && op_i == acc_alu_pkg::OP_SUM_MEM);
    cover property (op_i == acc_alu_pkg::OP_SUM_MEM ##1 op_i == acc_alu_pkg::OP_AND_MEM);
    cover property (op_i == acc_alu_pkg::OP_AND_IMM ##1 zero_flag_o);
    cover property (op_i == acc_alu_pkg::OP_SUM_MEM ##1 zero_flag_o);
endmodule // acc_alu_sva
bind acc_add_and_datapath acc_alu_sva #(.ADDR_W(ADDR_W)) acc_alu_sva_inst (.*);

// [tb/tb_top.sv]
// Purpose: random and corner ops against the slice
// Assumes: op codes as the package gives them
// Notes:   the load op refills the working register so the and ops see set bits
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 0, rst_b_i = 0, we;
    logic [2:0]  op = 3'h0;
    logic [7:0]  addr = 8'h00, imm = 8'h00, pa = 8'h00, rd, w, wa, wd;
    wire  [3:0]  f;
    logic [20:0] e = 21'h0;
    logic [31:0] seed = 32'h87A626F5;
    // load, two sums and two and-into-memory back to back on one byte, refused codes, sum to zero
    localparam logic [2:0] corner_op [12] = '{3'h4, 3'h1, 3'h1, 3'h3, 3'h6, 3'h6, 3'h2, 3'h0, 3'h5, 3'h7, 3'h4, 3'h1};
    int          bad_count = 0, checks_done = 0;
    always #25 mclk_i = ~mclk_i;
    acc_add_and_datapath acc_add_and_datapath_inst (.mclk_i, .rst_b_i, .op_i(acc_alu_pkg::alu_op_t'(op)),
        .mem_addr_i(addr), .mem_data_i(rd), .imm_i(imm), .working_register_o(w), .mem_we_o(we), .mem_waddr_o(wa),
        .mem_wdata_o(wd), .twos_complement_wrap_flag_o(f[3]), .zero_flag_o(f[2]), .low_nibble_carry_flag_o(f[1]),
        .carry_flag_o(f[0]));
    mem_model mem_model_inst (.mclk_i, .we_i(we), .waddr_i(wa), .wdata_i(wd), .raddr_i(addr), .rdata_o(rd));
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // {strobe, wdata, working, wrap, zero, nibble carry, carry}
    function automatic logic [20:0] model(logic [2:0] o, logic [7:0] a, d, x, logic [3:0] g);
        logic [8:0] s;
        logic [7:0] n;
        s = a + d;
        n = a & (o == 3'h2 ? x : d);
        case (o)
            3'h1: return {1'b1, s[7:0], a, a[7] == d[7] && s[7] != a[7], s[7:0] == 8'h00,
                5'(a[3:0]) + d[3:0] > 5'h0F, s[8]};
            3'h2, 3'h3: return {1'b0, 8'h00, n, g[3], n == 8'h00, g[1:0]};
            3'h6: return {1'b1, n, a, g[3], n == 8'h00, g[1:0]};
            3'h4: return {1'b0, 8'h00, x, g};
            default: return {1'b0, 8'h00, a, g};
        endcase
    endfunction
    task automatic chk(string n, logic [15:0] x, logic [15:0] y);
        checks_done++;
        if (x !== y)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, x, y);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge mclk_i);
        #1 rst_b_i = 1;
        for (int i = 0; i < 400; i++)
        begin
            @(posedge mclk_i);
            #1 chk("state", {3'h0, e[20], e[11:0]}, {3'h0, we, w, f});
            if (e[20])
                chk("write", {pa, e[19:12]}, {wa, wd});
            seed = xs(seed);
            op = i < 12 ? corner_op[i] : seed[2:0];
            addr = i == 11 ? 8'h00 : (i < 11 ? 8'hA5 : seed[15:8]);
            imm = i == 0 ? 8'hFF : (i == 10 ? 8'h5B : seed[23:16]);
            #1 e = model(op, e[11:4], (e[20] && pa == addr) ? e[19:12] : rd, imm, e[3:0]);
            pa = addr;
        end
        rst_b_i = 0;
        #1 chk("reset", 16'h0000, {3'h0, we, w, f});
        complete_run;
    end
    // spare time over the 400 ops and reset
    initial
    begin
        #30000;
        bad_count++;
        complete_run;
    end
endmodule // tb_top
